//--- rtl/exu_pkg.sv
package exu_pkg;
  // exception vectors
  localparam logic [7:0] VEC_DEBUG = 8'h01;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_BADOP = 8'h06;
  localparam logic [7:0] VEC_NODEV = 8'h07;
  localparam logic [7:0] VEC_DOUBLE = 8'h08;
  localparam logic [7:0] VEC_GP = 8'h0D;
  localparam logic [7:0] VEC_PAGE = 8'h0E;
  localparam logic [7:0] VEC_COPERR = 8'h10;
  localparam logic [7:0] VEC_SEG_LO = 8'h0A;
  localparam logic [7:0] VEC_SEG_HI = 8'h0D;
  // reset values
  localparam logic [31:0] START_ADDR = 32'hFFFFFFF0;
  localparam logic [31:0] IP_RESET = 32'h0000FFFF;
  localparam logic [15:0] CS_RESET = 16'hF000;
  localparam logic [31:0] CS_BASE_RESET = 32'hFFFF0000;
  localparam logic [31:0] CS_LIMIT_RESET = 32'h0000FFFF;
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [31:0] FLAGS_RESET = 32'h00000002;
  localparam logic [31:0] COMP_ID = 32'h00000A5A; // arbitrary id value
  // control word bits
  localparam int MCW_PE = 0;
  localparam int MCW_MP = 1;
  localparam int MCW_EM = 2;
  localparam int MCW_TS = 3;
  localparam int MCW_ET = 4;
  localparam int MCW_PG = 31;
  // startup delay: 350..450 core clock periods; 125 MHz core clock
  localparam int HOLD_MIN_PERIODS = 350;
  localparam int HOLD_CYCLES = HOLD_MIN_PERIODS + 25; // within window
  localparam logic [8:0] HOLD_CNT = 9'(HOLD_CYCLES);
  // register map (byte addresses)
  localparam logic [7:0] A_FLAGS = 8'h00;
  localparam logic [7:0] A_MCW = 8'h04;
  localparam logic [7:0] A_VEC = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_IP = 8'h10;
  localparam logic [7:0] A_DX = 8'h14;
  localparam logic [7:0] A_AX = 8'h18;
  localparam logic [7:0] A_UPPER = 8'h1C;
  // instruction boundary condition inputs
  typedef struct packed {
    logic dbg_trap;
    logic dbg_fault;
    logic fetch_seg;
    logic fetch_seg_np;  // 1: vector 11, 0: vector 13
    logic fetch_page;
    logic bad_opcode;
    logic prot_only;
    logic too_long;
    logic priv_viol;
    logic wait_op;
    logic esc_op;
    logic mem_seg;
    logic [7:0] mem_seg_vec;
    logic mem_page;
  } exu_cond_type;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HOLD = 2'b01,
    ST_SHUT = 2'b11
  } exu_state_type;
  // delivery stage within handler entry
  typedef enum logic [1:0] {
    EN_NONE = 2'b00,
    EN_SEG = 2'b01,
    EN_PAGE = 2'b11,
    EN_PAGE2 = 2'b10
  } exu_entry_type;
  typedef struct packed {
    exu_state_type st;
    exu_entry_type ent;
    logic [8:0] cnt;
    logic [31:0] flags;
    logic [31:0] mcw;
    logic [31:0] ip;
    logic [31:0] dx;
    logic [31:0] ax;
    logic upper_hi;
    logic [7:0] vec;
    logic vec_v;
    logic nmi_pend;
    logic fetch_go;
    logic [31:0] fetch_addr;
    logic run;
    logic ahb_pend;
    logic ahb_wr;
    logic [7:0] ahb_addr;
    logic [31:0] rdata;
    logic ready;
  } exu_state_all_type;
endpackage

//--- rtl/exu_core.sv
// Notes on behaviour
// - debug traps checked before debug faults
// - external interrupts are the third check
// - fetch segment faults precede fetch page faults
// - decode faults give vector 6 or 13
// - wait faults 7 when task and monitor set
// - escape faults 7 when emulate or task set
// - coprocessor error input raises vector 16
// - memory segment faults precede memory page faults
// - one exception per attempt, instruction restartable
// - non-page fault entering segment handler gives double fault
// - non-page fault entering page handler: double
// - second page fault repeats 14, third shuts down
// - reset stops execution and bus activity
// - fetch at top address 350-450 periods later
// - upper address lines high until far jump
// - reset loads the instruction pointer value
// - flags reset to two, upper bits undefined
// - control word cleared, type bit from detect
// - id in dx, self-test signature in accumulator
// - nmi before maskable interrupt at one boundary
// - nmi uses vector 2, maskable needs acknowledge
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
module exu_core (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic boundary_i,          // instruction boundary strobe
  input wire exu_pkg::exu_cond_type cond_i,
  input wire logic nmi_i,               // async pin
  input wire logic maskable_irq_input_i, // async pin
  input wire logic coproc_error_n_i,    // async pin, low = error
  input wire logic coproc_387_i,        // type detect strap
  input wire logic selftest_i,          // self-test requested
  input wire logic [31:0] selftest_sig_i,
  input wire logic entry_fault_i,       // fault while entering handler
  input wire logic entry_fault_page_i,  // that fault is a page fault
  input wire logic entry_done_i,        // handler entered
  input wire logic far_jump_i,          // intersegment jump or call done
  input wire logic [7:0] ack_vec_i,     // vector from acknowledge cycle
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [7:0] vec_o,             // vector to dispatch
  output logic vec_valid_o,             // one-cycle pulse
  output logic run_o,                   // execution and bus allowed
  output logic fetch_go_o,              // first fetch pulse
  output logic [31:0] fetch_addr_o,
  output logic upper_hi_o,              // upper_address_lines driven high
  output logic shutdown_o
);
  // reset release synchroniser
  logic [1:0] rst_sync_q;
  logic rst_n;
  // input synchronisers
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic nmi_s;
  logic irq_s;
  logic err_s;
  exu_pkg::exu_state_all_type s_q;
  exu_pkg::exu_state_all_type s_d;
  logic [7:0] sel_vec;
  logic sel_hit;
  logic irq_en;

  // two-flop reset release
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // pin synchronisers, second stage only is read
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {nmi_i, maskable_irq_input_i, ~coproc_error_n_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign nmi_s = pin_s2_q[2];
  assign irq_s = pin_s2_q[1];
  assign err_s = pin_s2_q[0];
  // interrupt enable flag lives in bit 9
  assign irq_en = s_q.flags[9];

  // segment-class vector test
  function automatic logic is_seg_vec(input logic [7:0] v);
    is_seg_vec = (v >= exu_pkg::VEC_SEG_LO) && (v <= exu_pkg::VEC_SEG_HI);
  endfunction

  // priority chain: first true condition wins
  always_comb begin
    sel_hit = 1'b1;
    sel_vec = exu_pkg::VEC_DEBUG;
    if (cond_i.dbg_trap || cond_i.dbg_fault) begin
      sel_vec = exu_pkg::VEC_DEBUG;
    end else if (nmi_s && !s_q.nmi_pend) begin
      sel_vec = exu_pkg::VEC_NMI;
    end else if (irq_s && irq_en) begin
      sel_vec = ack_vec_i;
    end else if (cond_i.fetch_seg) begin
      sel_vec = cond_i.fetch_seg_np ? 8'h0B : exu_pkg::VEC_GP;
    end else if (cond_i.fetch_page) begin
      sel_vec = exu_pkg::VEC_PAGE;
    end else if (cond_i.bad_opcode || (cond_i.prot_only && (!s_q.mcw[exu_pkg::MCW_PE] || s_q.flags[17]))) begin
      sel_vec = exu_pkg::VEC_BADOP;
    end else if (cond_i.too_long || cond_i.priv_viol) begin
      sel_vec = exu_pkg::VEC_GP;
    end else if (cond_i.wait_op && s_q.mcw[exu_pkg::MCW_TS] && s_q.mcw[exu_pkg::MCW_MP]) begin
      sel_vec = exu_pkg::VEC_NODEV;
    end else if (cond_i.esc_op && (s_q.mcw[exu_pkg::MCW_EM] || s_q.mcw[exu_pkg::MCW_TS])) begin
      sel_vec = exu_pkg::VEC_NODEV;
    end else if ((cond_i.wait_op || cond_i.esc_op) && err_s) begin
      sel_vec = exu_pkg::VEC_COPERR;
    end else if (cond_i.mem_seg) begin
      sel_vec = cond_i.mem_seg_vec;
    end else if (cond_i.mem_page) begin
      sel_vec = exu_pkg::VEC_PAGE;
    end else begin
      sel_hit = 1'b0;
    end
  end

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.vec_v = 1'b0;
    s_d.fetch_go = 1'b0;
    s_d.ready = 1'b1;
    case (s_q.st)
      exu_pkg::ST_HOLD: begin
        // strap capture at start of hold
        if (s_q.cnt == 9'h000) begin
          s_d.mcw[exu_pkg::MCW_ET] = coproc_387_i;
          s_d.ax = selftest_i ? selftest_sig_i : 32'h00000000;
        end
        if (s_q.cnt == exu_pkg::HOLD_CNT) begin
          s_d.st = exu_pkg::ST_RUN;
          s_d.run = 1'b1;
          s_d.fetch_go = 1'b1;
          s_d.fetch_addr = exu_pkg::START_ADDR;
        end else begin
          s_d.cnt = s_q.cnt + 9'h001;
        end
      end
      exu_pkg::ST_RUN: begin
        if (s_q.ent != exu_pkg::EN_NONE && entry_fault_i) begin
          s_d.vec_v = 1'b1;
          if (s_q.ent == exu_pkg::EN_PAGE2) begin
            s_d.st = exu_pkg::ST_SHUT;
            s_d.run = 1'b0;
            s_d.vec_v = 1'b0;
          end else if (s_q.ent == exu_pkg::EN_PAGE && entry_fault_page_i) begin
            s_d.vec = exu_pkg::VEC_PAGE;
            s_d.ent = exu_pkg::EN_PAGE2;
          end else if (s_q.ent == exu_pkg::EN_SEG && entry_fault_page_i) begin
            s_d.vec = exu_pkg::VEC_PAGE;
            s_d.ent = exu_pkg::EN_PAGE;
          end else begin
            s_d.vec = exu_pkg::VEC_DOUBLE;
            s_d.ent = exu_pkg::EN_PAGE2;
          end
        end else if (s_q.ent != exu_pkg::EN_NONE && entry_done_i) begin
          s_d.ent = exu_pkg::EN_NONE;
        end else if (boundary_i && sel_hit && s_q.ent == exu_pkg::EN_NONE) begin
          s_d.vec = sel_vec;
          s_d.vec_v = 1'b1;
          if (sel_vec == exu_pkg::VEC_NMI) begin
            s_d.nmi_pend = 1'b1;
            s_d.flags[9] = 1'b0;
          end
          if (is_seg_vec(sel_vec)) begin
            s_d.ent = exu_pkg::EN_SEG;
          end else if (sel_vec == exu_pkg::VEC_PAGE) begin
            s_d.ent = exu_pkg::EN_PAGE;
          end
        end
        // drop upper lines after far jump
        if (far_jump_i) begin
          s_d.upper_hi = 1'b0;
        end
      end
      exu_pkg::ST_SHUT: begin
        s_d.run = 1'b0;
      end
      default: begin
        s_d.st = exu_pkg::ST_SHUT;
      end
    endcase
    // bus data phase
    if (s_q.ahb_pend) begin
      if (s_q.ahb_wr) begin
        case (s_q.ahb_addr)
          exu_pkg::A_FLAGS: s_d.flags = hwdata_i | exu_pkg::FLAGS_RESET;
          exu_pkg::A_MCW: s_d.mcw = hwdata_i;
          exu_pkg::A_STAT: s_d.nmi_pend = s_q.nmi_pend & ~hwdata_i[0];
          default: s_d.ip = s_q.ip;
        endcase
      end
    end
    s_d.ahb_pend = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      s_d.ahb_pend = 1'b1;
      s_d.ahb_wr = hwrite_i;
      s_d.ahb_addr = haddr_i[7:0];
      case (haddr_i[7:0])
        exu_pkg::A_FLAGS: s_d.rdata = s_q.flags;
        exu_pkg::A_MCW: s_d.rdata = s_q.mcw;
        exu_pkg::A_VEC: s_d.rdata = {24'h000000, s_q.vec};
        exu_pkg::A_STAT: s_d.rdata = {28'h0000000, s_q.upper_hi, s_q.st == exu_pkg::ST_SHUT, s_q.run, s_q.nmi_pend};
        exu_pkg::A_IP: s_d.rdata = s_q.ip;
        exu_pkg::A_DX: s_d.rdata = s_q.dx;
        exu_pkg::A_AX: s_d.rdata = s_q.ax;
        default: s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // state register; reset values
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= exu_pkg::ST_HOLD;
      s_q.flags <= exu_pkg::FLAGS_RESET;
      s_q.ip <= exu_pkg::IP_RESET;
      s_q.dx <= exu_pkg::COMP_ID;
      s_q.upper_hi <= 1'b1;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata_o = s_q.rdata;
  assign hreadyout_o = s_q.ready;
  assign hresp_o = 1'b0;
  assign vec_o = s_q.vec;
  assign vec_valid_o = s_q.vec_v;
  assign run_o = s_q.run;
  assign fetch_go_o = s_q.fetch_go;
  assign fetch_addr_o = s_q.fetch_addr;
  assign upper_hi_o = s_q.upper_hi;
  assign shutdown_o = (s_q.st == exu_pkg::ST_SHUT);

  start_addr_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    fetch_go_o |-> fetch_addr_o == exu_pkg::START_ADDR) else $error("bad start address");
  hold_norun_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_q.st == exu_pkg::ST_HOLD |-> !run_o) else $error("run during hold");
  wait_fault_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s_q.st == exu_pkg::ST_RUN && s_q.ent == exu_pkg::EN_NONE && !entry_fault_i && !entry_done_i && boundary_i
     && cond_i.wait_op && !cond_i.dbg_trap && !cond_i.dbg_fault && !cond_i.fetch_seg && !cond_i.fetch_page
     && !cond_i.bad_opcode && !cond_i.prot_only && !cond_i.too_long && !cond_i.priv_viol
     && !(nmi_s && !s_q.nmi_pend) && !(irq_s && irq_en)
     && s_q.mcw[exu_pkg::MCW_TS] && s_q.mcw[exu_pkg::MCW_MP])
    |=> vec_valid_o && vec_o == exu_pkg::VEC_NODEV) else $error("wait check");
  debug_first_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s_q.st == exu_pkg::ST_RUN && s_q.ent == exu_pkg::EN_NONE && !entry_fault_i && !entry_done_i && boundary_i
     && cond_i.dbg_trap) |=> vec_valid_o && vec_o == exu_pkg::VEC_DEBUG) else $error("debug not first");
  nmi_first_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s_q.st == exu_pkg::ST_RUN && s_q.ent == exu_pkg::EN_NONE && !entry_fault_i && !entry_done_i && boundary_i
     && !cond_i.dbg_trap && !cond_i.dbg_fault && nmi_s && !s_q.nmi_pend) |=> vec_o == exu_pkg::VEC_NMI)
    else $error("nmi not chosen");
  shut_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s_q.st == exu_pkg::ST_RUN && s_q.ent == exu_pkg::EN_PAGE2 && entry_fault_i) |=> shutdown_o ##1 shutdown_o)
    else $error("no shutdown");
  dbl_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s_q.st == exu_pkg::ST_RUN && s_q.ent == exu_pkg::EN_SEG && entry_fault_i && !entry_fault_page_i)
    |=> vec_valid_o && vec_o == exu_pkg::VEC_DOUBLE) else $error("no double fault");
  upper_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !upper_hi_o |=> !upper_hi_o) else $error("upper lines rose");
  // vector pulses single cycle after boundary
  one_vec_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    vec_valid_o && !entry_fault_i |=> !vec_valid_o || $past(boundary_i)) else $error("extra vector");
endmodule

//--- testbench/exu_partner.sv
// far side: interrupt sources and numeric coprocessor pins
module exu_partner (
  input wire logic clk_i,
  input wire logic nmi_req_i,
  input wire logic irq_req_i,
  input wire logic err_req_i,
  input wire logic [7:0] irq_vec_i,
  output logic nmi_o,
  output logic irq_o,
  output logic coproc_error_n_o,
  output logic [7:0] ack_vec_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet pins at time zero
  initial begin
    nmi_o = 1'h0;
    irq_o = 1'h0;
    coproc_error_n_o = 1'h1;
    ack_vec_o = 8'h00;
  end
  // pins move on the falling edge, unrelated to core sampling
  always @(negedge clk_i) begin
    nmi_o <= nmi_req_i;
    irq_o <= irq_req_i;
    coproc_error_n_o <= ~err_req_i;
    ack_vec_o <= irq_req_i ? irq_vec_i : ~ack_vec_o;
  end
endmodule

//--- testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // core-side stimulus
  logic clk_i = 1'h0;
  logic resetn_i = 1'h0;
  logic boundary_i = 1'h0;
  exu_pkg::exu_cond_type cond_i = '0;
  logic entry_fault_i = 1'h0;
  logic entry_fault_page_i = 1'h0;
  logic entry_done_i = 1'h0;
  logic far_jump_i = 1'h0;
  // partner requests and pins
  logic nmi_req = 1'h0;
  logic irq_req = 1'h0;
  logic err_req = 1'h0;
  logic nmi_i;
  logic maskable_irq_input_i;
  logic coproc_error_n_i;
  logic [7:0] ack_vec_i;
  // bus master side
  logic hsel_i = 1'h0;
  logic hwrite_i = 1'h0;
  logic [1:0] htrans_i = 2'h0;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  // core outputs
  logic [7:0] vec_o;
  logic vec_valid_o;
  logic run_o;
  logic fetch_go_o;
  logic [31:0] fetch_addr_o;
  logic upper_hi_o;
  logic shutdown_o;
  int n_errors = 0;
  int n_checks = 0;
  logic [31:0] rd;
  // 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  exu_partner i_exu_partner (.clk_i(clk_i), .nmi_req_i(nmi_req), .irq_req_i(irq_req), .err_req_i(err_req),
    .irq_vec_i(8'h40), .nmi_o(nmi_i), .irq_o(maskable_irq_input_i), .coproc_error_n_o(coproc_error_n_i),
    .ack_vec_o(ack_vec_i));
  exu_core i_exu_core (.clk_i, .resetn_i, .boundary_i, .cond_i, .nmi_i, .maskable_irq_input_i,
    .coproc_error_n_i, .coproc_387_i(1'h1), .selftest_i(1'h1), .selftest_sig_i(32'h1234ABCD),
    .entry_fault_i, .entry_fault_page_i, .entry_done_i, .far_jump_i, .ack_vec_i, .hsel_i, .haddr_i,
    .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
    .hresp_o, .vec_o, .vec_valid_o, .run_o, .fetch_go_o, .fetch_addr_o, .upper_hi_o, .shutdown_o);
  // closing report, the only exit
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // compare and tally
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for a core signal: 0 ready, 1 vector valid, 2 fetch start
  task automatic wt(input int k, input int n, output int i);
    logic s;
    for (i = 0; i < n; i++) begin
      @(posedge clk_i);
      s = (k == 0) ? hreadyout_o : (k == 1) ? vec_valid_o : fetch_go_o;
      if (s === 1'h1) break;
    end
    if (i == n) begin
      n_errors++;
      $display("wrong value handshake %0d expected 1 seen timeout", k);
      results();
    end
  endtask
  // one single word transfer, read data left in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    hsel_i <= 1'h1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    wt(0, 50, i);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wt(0, 50, i);
    rd = hrdata_o;
  endtask
  // read and compare the masked bits
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    ahb(1'h0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  // expect exactly one vector pulse
  task automatic getv(input logic [7:0] e);
    int i;
    wt(1, 20, i);
    chk("vector", {24'h0, e}, {24'h0, vec_o});
    @(posedge clk_i);
    chk("vector pulse", 32'h0, 32'(vec_valid_o));
  endtask
  // end of handler entry
  task automatic fin();
    entry_done_i <= 1'h1;
    @(posedge clk_i);
    entry_done_i <= 1'h0;
  endtask
  // fault seen while entering a handler
  task automatic efp(input logic pg);
    entry_fault_i <= 1'h1;
    entry_fault_page_i <= pg;
    @(posedge clk_i);
    entry_fault_i <= 1'h0;
  endtask
  // conditions at one boundary; f closes the handler entry
  task automatic bt(input exu_pkg::exu_cond_type c, input logic [7:0] e, input logic f);
    boundary_i <= 1'h1;
    cond_i <= c;
    @(posedge clk_i);
    boundary_i <= 1'h0;
    getv(e);
    if (f) begin
      fin();
    end
  endtask
  // coprocessor opcode with control word m; w picks wait, else escape
  task automatic cop(input logic [31:0] m, input logic w, input logic er, input logic [7:0] e);
    err_req <= er;
    ahb(1'h1, 8'h04, m);
    repeat (4) @(posedge clk_i);
    bt('{wait_op: w, esc_op: ~w, default: 0}, e, 1'h1);
  endtask
  // reset pulse and start-up timing
  task automatic rst();
    int i;
    resetn_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    chk("run in reset", 32'h0, 32'(run_o));
    chk("upper lines in reset", 32'h1, 32'(upper_hi_o));
    resetn_i <= 1'h1;
    wt(2, 600, i);
    chk("start delay", 32'h1, 32'(i + 1 >= 350 && i + 1 <= 450));
    chk("start address", exu_pkg::START_ADDR, fetch_addr_o);
    @(posedge clk_i);
    chk("run after start", 32'h1, 32'(run_o));
    chk("shutdown after reset", 32'h0, 32'(shutdown_o));
  endtask
  // main sequence
  initial begin
    @(posedge clk_i);
    rst();
    rdc(8'h00, 32'h0003FFFF, exu_pkg::FLAGS_RESET, "flags");
    rdc(8'h04, 32'h8000001F, 32'h00000010, "control word");
    rdc(8'h10, 32'hFFFFFFFF, exu_pkg::IP_RESET, "ip");
    rdc(8'h14, 32'hFFFFFFFF, exu_pkg::COMP_ID, "dx");
    rdc(8'h18, 32'hFFFFFFFF, 32'h1234ABCD, "ax");
    rdc(8'h0C, 32'h0000000F, 32'h0000000A, "status");
    ahb(1'h1, 8'h20, 32'hFFFFFFFF);
    rdc(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped");
    $display("test reset finished");
    ahb(1'h1, 8'h00, 32'h00000202);
    nmi_req <= 1'h1;
    irq_req <= 1'h1;
    repeat (4) @(posedge clk_i);
    bt('{dbg_trap: 1, dbg_fault: 1, fetch_seg: 1, default: 0}, 8'h01, 1'h1);
    bt('{fetch_seg: 1, default: 0}, 8'h02, 1'h1);
    nmi_req <= 1'h0;
    ahb(1'h1, 8'h00, 32'h00000202);
    bt('{fetch_page: 1, default: 0}, 8'h40, 1'h1);
    irq_req <= 1'h0;
    rdc(8'h0C, 32'h1, 32'h1, "nmi pending");
    ahb(1'h1, 8'h0C, 32'h1);
    rdc(8'h0C, 32'h1, 32'h0, "nmi cleared");
    $display("test interrupts finished");
    bt('{fetch_seg: 1, fetch_seg_np: 1, fetch_page: 1, bad_opcode: 1, default: 0}, 8'h0B, 1'h1);
    bt('{fetch_seg: 1, fetch_page: 1, default: 0}, 8'h0D, 1'h1);
    bt('{fetch_page: 1, bad_opcode: 1, default: 0}, 8'h0E, 1'h1);
    bt('{bad_opcode: 1, wait_op: 1, default: 0}, 8'h06, 1'h1);
    bt('{prot_only: 1, default: 0}, 8'h06, 1'h1);
    bt('{too_long: 1, esc_op: 1, default: 0}, 8'h0D, 1'h1);
    bt('{mem_seg: 1, mem_seg_vec: 8'h0C, mem_page: 1, default: 0}, 8'h0C, 1'h1);
    bt('{mem_page: 1, default: 0}, 8'h0E, 1'h1);
    ahb(1'h1, 8'h04, 32'h11);
    bt('{priv_viol: 1, mem_page: 1, default: 0}, 8'h0D, 1'h1);
    $display("test faults finished");
    cop(32'h1A, 1'h1, 1'h0, 8'h07);
    cop(32'h12, 1'h1, 1'h1, 8'h10);
    cop(32'h18, 1'h1, 1'h1, 8'h10);
    cop(32'h14, 1'h1, 1'h1, 8'h10);
    cop(32'h14, 1'h0, 1'h0, 8'h07);
    cop(32'h18, 1'h0, 1'h1, 8'h07);
    cop(32'h12, 1'h0, 1'h1, 8'h10);
    $display("test coprocessor finished");
    err_req <= 1'h0;
    far_jump_i <= 1'h1;
    @(posedge clk_i);
    far_jump_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    chk("upper lines", 32'h0, 32'(upper_hi_o));
    bt('{fetch_seg: 1, default: 0}, 8'h0D, 1'h0);
    efp(1'h0);
    getv(8'h08);
    fin();
    bt('{mem_seg: 1, mem_seg_vec: 8'h0A, default: 0}, 8'h0A, 1'h0);
    efp(1'h0);
    getv(8'h08);
    fin();
    bt('{mem_page: 1, default: 0}, 8'h0E, 1'h0);
    efp(1'h0);
    getv(8'h08);
    fin();
    bt('{fetch_page: 1, default: 0}, 8'h0E, 1'h0);
    efp(1'h1);
    getv(8'h0E);
    efp(1'h1);
    repeat (2) @(posedge clk_i);
    chk("shutdown", 32'h1, 32'(shutdown_o));
    rst();
    chk("upper lines again", 32'h1, 32'(upper_hi_o));
    $display("test entry finished");
    results();
  end
endmodule
